// File: design/ekr_pkg.sv
// Constants for the exposure knee, soft reset and binning register bank
package ekr_pkg;
    // Register offsets on the word register port
    localparam logic [7:0]  EKR_OFS_KNEE      = 8'h0A;
    localparam logic [7:0]  EKR_OFS_TOTAL     = 8'h0B;
    localparam logic [7:0]  EKR_OFS_RESET     = 8'h0C;
    localparam logic [7:0]  EKR_OFS_READMODE  = 8'h0D;
    // Field positions
    localparam int          EKR_KNEE_T2_LSB   = 0;
    localparam int          EKR_KNEE_T3_LSB   = 4;
    localparam int          EKR_KNEE_AUTO_BIT = 8;
    localparam int          EKR_KNEE_SGL_BIT  = 9;
    localparam int          EKR_RST_CORE_BIT  = 0;
    localparam int          EKR_RST_AUTO_BIT  = 1;
    // Values after reset
    localparam logic [3:0]  EKR_T2_RST        = 4'h4;
    localparam logic [3:0]  EKR_T3_RST        = 4'h6;
    localparam logic        EKR_AUTO_RST      = 1'b1;
    localparam logic        EKR_SGL_RST       = 1'b0;
    localparam logic [14:0] EKR_TOTAL_RST     = 15'h01E0;
    localparam logic [1:0]  EKR_BIN_RST       = 2'h0;
    localparam logic [1:0]  EKR_BIN_BAD       = 2'h3;
    // Internal reset pulse length in clock cycles
    localparam int          EKR_RST_CYCLES    = 15;
endpackage

// File: design/ekr_rst_if.sv
// Carrier between the register bank and a reset pulse generator
interface ekr_rst_if;
    logic start;
    logic rst_n;
    modport bank (output start, input rst_n);
    modport gen  (input start, output rst_n);
endinterface

// File: design/ekr_rst_pulse.sv
// Active-low reset pulse of fixed length, retriggered by each start
module ekr_rst_pulse
    import ekr_pkg::*;
#(
    parameter int CYCLES = EKR_RST_CYCLES
) (
    // Clock and reset
    input  wire logic clk_in,
    input  wire logic sys_rst_in,
    // Pulse request and reset out
    ekr_rst_if.gen    rst
);
    localparam int CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] CNT_LOAD = CW'(CYCLES);

    logic [CW-1:0] cnt_q;

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            cnt_q <= '0;
        end else if (rst.start) begin
            cnt_q <= CNT_LOAD;
        end else if (cnt_q != '0) begin
            cnt_q <= cnt_q - CW'(1);
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            rst.rst_n <= 1'b1;
        end else begin
            rst.rst_n <= !(rst.start || cnt_q > CW'(1));
        end
    end
endmodule

// File: design/ekr_regs.sv
// Knee timing, total integration, soft reset and row binning register bank
// What this block does
// - Second knee = total times half^ratio
// - Third knee likewise; first is remainder
// - Ratio and total changes apply next frame
// - Bit 8 enables knee auto adjust
// - Bit 9 selects single knee
// - Total rows used only without auto exposure
// - Core reset drops frame, keeps registers
// - Reset bits self-clear, pulse 15 cycles low
// - Auto reset hits gain/exposure loop only
// - Row bin 0 normal, 1 two rows
// - Row bin 2 four rows, 3 invalid
// - Manual knee rows when auto off, HDR on
module ekr_regs
    import ekr_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_in,
    input  wire logic        sys_rst_in,
    // Word register port from the serial interface
    input  wire logic [7:0]  reg_addr_in,
    input  wire logic [15:0] reg_wdata_in,
    input  wire logic        reg_wr_in,
    input  wire logic        reg_rd_in,
    output logic      [15:0] reg_rdata_out,
    output logic             reg_rvalid_out,
    // Frame timing and exposure sources
    input  wire logic        frame_start_in,
    input  wire logic        auto_exposure_loop_en_in,
    input  wire logic [14:0] auto_exposure_rows_in,
    input  wire logic        hdr_en_in,
    input  wire logic [14:0] manual_knee1_rows_in,
    input  wire logic [14:0] manual_knee2_rows_in,
    // Exposure interval outputs
    output logic      [14:0] knee_t1_rows_out,
    output logic      [14:0] knee_t2_rows_out,
    output logic      [14:0] knee_t3_rows_out,
    output logic      [14:0] integration_rows_out,
    output logic             single_knee_out,
    output logic             knee_auto_out,
    // Binning
    output logic      [1:0]  row_bin_out,
    output logic      [2:0]  rows_per_output_out,
    // Soft resets
    output logic             frame_abort_out,
    output logic             core_rst_n_out,
    output logic             auto_rst_n_out
);
    ekr_rst_if core_if ();
    ekr_rst_if auto_if ();

    logic [3:0]  t2_exp_q;
    logic [3:0]  t3_exp_q;
    logic        auto_q;
    logic        sgl_q;
    logic [14:0] total_q;
    logic [1:0]  bin_q;
    logic        core_start_q;
    logic        auto_start_q;
    logic [14:0] total_d;
    logic [14:0] t1_d;
    logic [14:0] t2_d;
    logic [14:0] t3_d;
    logic [14:0] t2_auto;
    logic [14:0] t3_auto;
    logic        wr_knee;
    logic        wr_total;
    logic        wr_reset;
    logic        wr_mode;

    assign wr_knee  = reg_wr_in && reg_addr_in == EKR_OFS_KNEE;
    assign wr_total = reg_wr_in && reg_addr_in == EKR_OFS_TOTAL;
    assign wr_reset = reg_wr_in && reg_addr_in == EKR_OFS_RESET;
    assign wr_mode  = reg_wr_in && reg_addr_in == EKR_OFS_READMODE;

    // Register storage, untouched by the soft resets
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            t2_exp_q <= EKR_T2_RST;
            t3_exp_q <= EKR_T3_RST;
            auto_q   <= EKR_AUTO_RST;
            sgl_q    <= EKR_SGL_RST;
        end else if (wr_knee) begin
            t2_exp_q <= reg_wdata_in[EKR_KNEE_T2_LSB +: 4];
            t3_exp_q <= reg_wdata_in[EKR_KNEE_T3_LSB +: 4];
            auto_q   <= reg_wdata_in[EKR_KNEE_AUTO_BIT];
            sgl_q    <= reg_wdata_in[EKR_KNEE_SGL_BIT];
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            total_q <= EKR_TOTAL_RST;
        end else if (wr_total) begin
            total_q <= reg_wdata_in[14:0];
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            bin_q <= EKR_BIN_RST;
        end else if (wr_mode && reg_wdata_in[1:0] != EKR_BIN_BAD) begin
            bin_q <= reg_wdata_in[1:0];
        end
    end

    // Soft reset bits are strobes only, never stored
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            core_start_q <= 1'b0;
            auto_start_q <= 1'b0;
        end else begin
            core_start_q <= wr_reset && reg_wdata_in[EKR_RST_CORE_BIT];
            auto_start_q <= wr_reset && reg_wdata_in[EKR_RST_AUTO_BIT];
        end
    end

    assign core_if.start = core_start_q;
    assign auto_if.start = auto_start_q;

    ekr_rst_pulse #(.CYCLES(EKR_RST_CYCLES)) u_core_rst (
        .clk_in     (clk_in),
        .sys_rst_in (sys_rst_in),
        .rst        (core_if)
    );

    ekr_rst_pulse #(.CYCLES(EKR_RST_CYCLES)) u_auto_rst (
        .clk_in     (clk_in),
        .sys_rst_in (sys_rst_in),
        .rst        (auto_if)
    );

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            core_rst_n_out  <= 1'b1;
            auto_rst_n_out  <= 1'b1;
            frame_abort_out <= 1'b0;
        end else begin
            core_rst_n_out  <= core_if.rst_n;
            auto_rst_n_out  <= auto_if.rst_n && core_if.rst_n;
            frame_abort_out <= core_start_q;
        end
    end

    // Interval computation for the coming frame
    always_comb begin
        total_d = auto_exposure_loop_en_in ? auto_exposure_rows_in : total_q;
        t2_auto = total_d >> t2_exp_q;
        t3_auto = sgl_q ? 15'h0000 : (total_d >> t3_exp_q);
        t1_d    = total_d - t2_auto - t3_auto;
        t2_d    = t2_auto;
        t3_d    = t3_auto;
        if (!auto_q && hdr_en_in) begin
            t1_d = manual_knee1_rows_in;
            t2_d = manual_knee2_rows_in - manual_knee1_rows_in;
            t3_d = total_d - manual_knee2_rows_in;
        end else if (!auto_q) begin
            t1_d = total_d;
            t2_d = 15'h0000;
            t3_d = 15'h0000;
        end
    end

    // Active values latch at frame start or on every cycle while the internal core reset is low
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            knee_t1_rows_out     <= EKR_TOTAL_RST - (EKR_TOTAL_RST >> EKR_T2_RST) - (EKR_TOTAL_RST >> EKR_T3_RST);
            knee_t2_rows_out     <= EKR_TOTAL_RST >> EKR_T2_RST;
            knee_t3_rows_out     <= EKR_TOTAL_RST >> EKR_T3_RST;
            integration_rows_out <= EKR_TOTAL_RST;
            single_knee_out      <= EKR_SGL_RST;
            knee_auto_out        <= EKR_AUTO_RST;
            row_bin_out          <= EKR_BIN_RST;
        end else if (frame_start_in || !core_if.rst_n) begin
            knee_t1_rows_out     <= t1_d;
            knee_t2_rows_out     <= t2_d;
            knee_t3_rows_out     <= t3_d;
            integration_rows_out <= total_d;
            single_knee_out      <= sgl_q;
            knee_auto_out        <= auto_q;
            row_bin_out          <= bin_q;
        end
    end

    // Rows combined per output row; frame rate rises by the same factor
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            rows_per_output_out <= 3'h1;
        end else if (frame_start_in || !core_if.rst_n) begin
            case (bin_q)
                2'h1:    rows_per_output_out <= 3'h2;
                2'h2:    rows_per_output_out <= 3'h4;
                default: rows_per_output_out <= 3'h1;
            endcase
        end
    end

    // Read-back, one cycle after the read strobe
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            reg_rdata_out  <= 16'h0000;
            reg_rvalid_out <= 1'b0;
        end else begin
            reg_rvalid_out <= reg_rd_in;
            if (reg_rd_in) begin
                case (reg_addr_in)
                    EKR_OFS_KNEE:     reg_rdata_out <= {6'h00, sgl_q, auto_q, t3_exp_q, t2_exp_q};
                    EKR_OFS_TOTAL:    reg_rdata_out <= {1'b0, total_q};
                    EKR_OFS_READMODE: reg_rdata_out <= {14'h0000, bin_q};
                    EKR_OFS_RESET:    reg_rdata_out <= 16'h0000;
                    default:          reg_rdata_out <= 16'h0000;
                endcase
            end
        end
    end
endmodule

// File: verif/ekr_regs_sva.sv
// Port checker for the knee, reset and binning register bank
module ekr_regs_sva
    import ekr_pkg::*;
(
    // Clock, reset and register port
    input wire logic        clk_in,
    input wire logic        sys_rst_in,
    input wire logic [7:0]  reg_addr_in,
    input wire logic [15:0] reg_wdata_in,
    input wire logic        reg_wr_in,
    input wire logic        reg_rd_in,
    input wire logic [15:0] reg_rdata_out,
    input wire logic        frame_start_in,
    // Outputs under watch
    input wire logic [14:0] knee_t1_rows_out,
    input wire logic [14:0] knee_t2_rows_out,
    input wire logic [14:0] knee_t3_rows_out,
    input wire logic [14:0] integration_rows_out,
    input wire logic        single_knee_out,
    input wire logic        knee_auto_out,
    input wire logic [1:0]  row_bin_out,
    input wire logic [2:0]  rows_per_output_out,
    input wire logic        frame_abort_out,
    input wire logic        core_rst_n_out,
    input wire logic        auto_rst_n_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);
    logic rst_wr;
    assign rst_wr = reg_wr_in && reg_addr_in == EKR_OFS_RESET;
    // Fifteen low cycles split to keep repetitions short
    sequence core_low_run;
        !core_rst_n_out [*8] ##1 !core_rst_n_out [*7];
    endsequence
    sequence abort_then_low;
        frame_abort_out ##1 !core_rst_n_out;
    endsequence
    core_pulse_len_a: assert property ($fell(core_rst_n_out) |-> core_low_run ##1 core_rst_n_out)
        else $error("core reset pulse length wrong");
    core_abort_a: assert property (rst_wr && reg_wdata_in[0] |-> ##2 abort_then_low)
        else $error("core reset did not drop frame");
    auto_only_a: assert property (rst_wr && reg_wdata_in[1:0] == 2'h2 && core_rst_n_out
        |-> ##3 !auto_rst_n_out && core_rst_n_out) else $error("auto loop reset wrong");
    first_remainder_a: assert property (knee_auto_out
        |-> knee_t1_rows_out == integration_rows_out - knee_t2_rows_out - knee_t3_rows_out)
        else $error("first interval not remainder");
    single_knee_a: assert property (knee_auto_out && single_knee_out |-> knee_t3_rows_out == 15'h0000)
        else $error("third interval not zero");
    bin_rows_a: assert property (row_bin_out != EKR_BIN_BAD && rows_per_output_out == 3'h1 << row_bin_out)
        else $error("row binning mismatch");
    frame_hold_a: assert property (!frame_start_in && !frame_abort_out && core_rst_n_out
        |=> $stable(integration_rows_out) && $stable(row_bin_out)) else $error("value applied mid frame");
    reset_reads_zero_a: assert property (reg_rd_in && reg_addr_in == EKR_OFS_RESET |=> reg_rdata_out == 16'h0000)
        else $error("reset register read nonzero");
endmodule

bind ekr_regs ekr_regs_sva ekr_regs_sva_i (.clk_in, .sys_rst_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
    .reg_rd_in, .reg_rdata_out, .frame_start_in, .knee_t1_rows_out, .knee_t2_rows_out, .knee_t3_rows_out,
    .integration_rows_out, .single_knee_out, .knee_auto_out, .row_bin_out, .rows_per_output_out,
    .frame_abort_out, .core_rst_n_out, .auto_rst_n_out);

// File: verif/ekr_regs_bench.sv
// Self-checking bench for the knee, reset and binning register bank
module ekr_regs_bench
    import ekr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_in, sys_rst_in, reg_wr_in, reg_rd_in, frame_start_in, hdr_en_in;
    logic        auto_exposure_loop_en_in, reg_rvalid_out, single_knee_out, knee_auto_out;
    logic        frame_abort_out, core_rst_n_out, auto_rst_n_out;
    logic [7:0]  reg_addr_in;
    logic [15:0] reg_wdata_in, reg_rdata_out;
    logic [14:0] auto_exposure_rows_in, manual_knee1_rows_in, manual_knee2_rows_in;
    logic [14:0] knee_t1_rows_out, knee_t2_rows_out, knee_t3_rows_out, integration_rows_out;
    logic [1:0]  row_bin_out;
    logic [2:0]  rows_per_output_out;
    int          err_total, check_count;
    ekr_regs ekr_regs_i (
        .clk_in, .sys_rst_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out,
        .reg_rvalid_out, .frame_start_in, .auto_exposure_loop_en_in, .auto_exposure_rows_in, .hdr_en_in,
        .manual_knee1_rows_in, .manual_knee2_rows_in, .knee_t1_rows_out, .knee_t2_rows_out, .knee_t3_rows_out,
        .integration_rows_out, .single_knee_out, .knee_auto_out, .row_bin_out, .rows_per_output_out,
        .frame_abort_out, .core_rst_n_out, .auto_rst_n_out
    );
    initial begin
        clk_in = 1'b0;
        forever #4 clk_in = ~clk_in;
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= 1'b1;
        @(posedge clk_in);
        reg_wr_in <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        @(posedge clk_in);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        @(posedge clk_in);
        reg_rd_in <= 1'b0;
        #1 chk(reg_rdata_out, e);
        chk(16'(reg_rvalid_out), 16'h0001);
    endtask
    task automatic frm();
        @(posedge clk_in);
        frame_start_in <= 1'b1;
        @(posedge clk_in);
        frame_start_in <= 1'b0;
        #1;
    endtask
    task automatic kn(input logic [14:0] t1, input logic [14:0] t2, input logic [14:0] t3);
        chk(knee_t1_rows_out, t1);
        chk(knee_t2_rows_out, t2);
        chk(knee_t3_rows_out, t3);
    endtask
    // Counts low cycles of both resets and abort pulses after one write
    task automatic srst(input logic [15:0] d, input int ec, input int ea, input int eb);
        int nc, na, nb;
        nc = 0;
        na = 0;
        nb = 0;
        wr(EKR_OFS_RESET, d);
        repeat (30) begin
            @(posedge clk_in);
            #1;
            nc += (core_rst_n_out === 1'b0);
            na += (auto_rst_n_out === 1'b0);
            nb += (frame_abort_out === 1'b1);
        end
        chk(16'(nc), 16'(ec));
        chk(16'(na), 16'(ea));
        chk(16'(nb), 16'(eb));
    endtask
    task automatic give_verdict();
        $display("checks %0d, mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge clk_in);
        err_total++;
        give_verdict();
    end
    initial begin
        {reg_addr_in, reg_wdata_in, reg_wr_in, reg_rd_in, frame_start_in} <= '0;
        {auto_exposure_loop_en_in, auto_exposure_rows_in, hdr_en_in} <= '0;
        manual_knee1_rows_in <= 15'h0064;
        manual_knee2_rows_in <= 15'h00C8;
        sys_rst_in <= 1'b1;
        repeat (10) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        rd(EKR_OFS_KNEE, 16'h0164);
        rd(EKR_OFS_TOTAL, 16'h01E0);
        kn(15'h01BB, 15'h001E, 15'h0007);
        chk(16'(knee_auto_out), 16'h0001);
        chk(16'(single_knee_out), 16'h0000);
        $display("defaults done");
        wr(EKR_OFS_TOTAL, 16'h0100);
        wr(EKR_OFS_KNEE, 16'h012F);
        kn(15'h01BB, 15'h001E, 15'h0007);
        frm();
        kn(15'h00C0, 15'h0000, 15'h0040);
        wr(EKR_OFS_KNEE, 16'h0321);
        rd(EKR_OFS_KNEE, 16'h0321);
        frm();
        kn(15'h0080, 15'h0080, 15'h0000);
        chk(16'(single_knee_out), 16'h0001);
        $display("knee ratios done");
        wr(EKR_OFS_KNEE, 16'h0000);
        hdr_en_in <= 1'b1;
        frm();
        kn(15'h0064, 15'h0064, 15'h0038);
        chk(16'(knee_auto_out), 16'h0000);
        @(posedge clk_in);
        hdr_en_in <= 1'b0;
        auto_exposure_loop_en_in <= 1'b1;
        auto_exposure_rows_in <= 15'h0040;
        frm();
        kn(15'h0040, 15'h0000, 15'h0000);
        chk(integration_rows_out, 16'h0040);
        @(posedge clk_in);
        auto_exposure_loop_en_in <= 1'b0;
        $display("manual modes done");
        wr(EKR_OFS_TOTAL, 16'hFFFF);
        rd(EKR_OFS_TOTAL, 16'h7FFF);
        wr(8'h20, 16'h1234);
        rd(8'h20, 16'h0000);
        for (int b = 0; b < 3; b++) begin
            wr(EKR_OFS_READMODE, 16'(b));
            frm();
            chk(rows_per_output_out, 16'(1 << b));
            chk(row_bin_out, 16'(b));
        end
        wr(EKR_OFS_READMODE, 16'h0003);
        rd(EKR_OFS_READMODE, 16'h0002);
        frm();
        chk(row_bin_out, 16'h0002);
        $display("binning done");
        srst(16'h0001, 15, 15, 1);
        srst(16'h0002, 0, 15, 0);
        rd(EKR_OFS_RESET, 16'h0000);
        rd(EKR_OFS_TOTAL, 16'h7FFF);
        $display("soft resets done");
        // System reset in mid run restores every default
        @(posedge clk_in);
        sys_rst_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        rd(EKR_OFS_KNEE, 16'h0164);
        rd(EKR_OFS_TOTAL, 16'h01E0);
        kn(15'h01BB, 15'h001E, 15'h0007);
        chk(16'(rows_per_output_out), 16'h0001);
        $display("system reset done");
        give_verdict();
    end
endmodule
